// >>> hw/power_mode_pkg.sv
// constants shared by the power mode and clock gating logic
// assumes a 200 MHz system clock and an AXI4-Lite register bus
package power_mode_pkg;

   // register byte addresses
   localparam logic [31:0] POWER_MODE_CONTROL_ADDR      = 32'hE01FC0C0;
   localparam logic [31:0] PERIPHERAL_CLOCK_ENABLE_ADDR = 32'hE01FC0C4;

   // values after reset
   localparam logic [1:0]  POWER_MODE_CONTROL_RESET      = 2'h0;
   localparam logic [31:0] PERIPHERAL_CLOCK_ENABLE_RESET = 32'h00001FBE;
   // bits that hold state; all others read as zero
   localparam logic [31:0] PERIPHERAL_CLOCK_ENABLE_USED  = 32'h0081FFBE;

   // mode bit positions
   localparam int PROCESSOR_SLEEP_BIT = 0;
   localparam int DEEP_SLEEP_BIT      = 1;

   // gate bit positions
   localparam int TIMER0_GATE         = 1;
   localparam int TIMER1_GATE         = 2;
   localparam int SERIAL0_GATE        = 3;
   localparam int SERIAL1_GATE        = 4;
   localparam int PULSE_WIDTH_GATE    = 5;
   localparam int TWO_WIRE_GATE       = 7;
   localparam int SERIAL_PORT0_GATE   = 8;
   localparam int CALENDAR_CLOCK_GATE = 9;
   localparam int SERIAL_PORT1_GATE   = 10;
   localparam int EXTERNAL_MEMORY_GATE = 11;
   localparam int CONVERTER_GATE      = 12;
   localparam int FIELD_BUS1_GATE     = 13;
   localparam int SYNC_SERIAL_GATE    = 23;

   // oscillator restart time after a wake from power-down
   localparam int CLOCK_PERIOD_PS   = 5000;
   localparam int OSC_START_NS      = 1000;
   localparam int OSC_START_CYCLES  =
      (OSC_START_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // peripheral clock divide, one enable pulse per period
   localparam int PCLK_DIVIDE = 4;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // operating modes; run to idle and back are one bit apart
   typedef enum logic [1:0] {
      MODE_RUN  = 2'h0,
      MODE_DOWN = 2'h1,
      MODE_WAKE = 2'h3,
      MODE_IDLE = 2'h2
   } mode_t;

endpackage

// >>> hw/pin_sync3.sv
// three-stage synchroniser for a group of asynchronous pins
// assumes one system clock; output moves once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
   parameter int WIDTH = 4
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);

   initial begin
      if (WIDTH < 1) $error("pin_sync3 needs at least one pin");
   end

   // one chain per pin; first stage feeds only the second
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
         end else begin
            s1 <= pin[i];
            s2 <= s1;
            s3 <= s2;
         end
      end
      // hold the last agreed value while the stages disagree
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            level[i] <= 1'b0;
         end else if (s2 == s3) begin
            level[i] <= s3;
         end
      end
   end

endmodule

// >>> hw/clock_gate_bank.sv
// bank of clock enables for the gated peripherals
// assumes peripherals qualify their logic with enable and pclk_tick
`timescale 1ns/1ps
module clock_gate_bank #(
   parameter int WIDTH = 32
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             pclk_tick,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] request,
   input  wire logic [WIDTH-1:0] reset_value,
   output logic      [WIDTH-1:0] enable
);

   initial begin
      if (WIDTH < 1) $error("clock_gate_bank needs a width");
   end

   // enables move only on a peripheral clock tick, and once in the first cycle after reset, so no pulse is cut short
   for (genvar i = 0; i < WIDTH; i++) begin : g_gate
      logic rst_q;
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            rst_q <= 1'b1;
         end else begin
            rst_q <= 1'b0;
         end
      end
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            enable[i] <= 1'b0;
         end else if (rst_q) begin
            enable[i] <= reset_value[i] & run;
         end else if (pclk_tick) begin
            enable[i] <= request[i] & run;
         end
      end
   end

   a_gate_stable: assert property (@(posedge clock) disable iff (!rst_n)
      !pclk_tick && !$past(!rst_n) |=> $stable(enable))
      else $error("gate enable moved between ticks");

   a_gate_off: assert property (@(posedge clock) disable iff (!rst_n)
      pclk_tick && !run |=> enable == '0)
      else $error("gate enable stayed on while clocks stopped");

endmodule

// >>> hw/power_mode_clock_gating.sv
// power mode control and peripheral clock gating with an AXI4-Lite slave
// assumes one 200 MHz clock, interrupts already masked by the controller,
// and wake pins asynchronous to the clock
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module power_mode_clock_gating #(
   parameter int IRQ_COUNT  = 16,
   parameter int WAKE_COUNT = 4
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [31:0]           awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [31:0]           araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire logic [IRQ_COUNT-1:0]  periph_irq,
   input  wire logic [WAKE_COUNT-1:0] ext_wake,
   output logic                       cpu_clock_en,
   output logic                       cpu_resume,
   output logic                       osc_enable,
   output logic                       pin_hold,
   output logic                       always_on_en,
   output logic [31:0]                periph_clock_en,
   output logic                       pclk_tick,
   output logic                       ssp_select
);

   initial begin
      if (IRQ_COUNT < 1 || WAKE_COUNT < 1)
         $error("need at least one interrupt and one wake pin");
      if (power_mode_pkg::OSC_START_CYCLES < 2 ||
          power_mode_pkg::OSC_START_CYCLES > 255)
         $error("oscillator start count must fit eight bits");
      // the tick divider is a two-bit counter
      if (power_mode_pkg::PCLK_DIVIDE < 2 ||
          power_mode_pkg::PCLK_DIVIDE > 4)
         $error("peripheral divide must lie between two and four");
   end

   localparam logic [7:0] START_CYCLES =
      8'(power_mode_pkg::OSC_START_CYCLES);
   localparam logic [1:0] TICK_LAST =
      2'(power_mode_pkg::PCLK_DIVIDE - 1);

   power_mode_pkg::mode_t state;
   power_mode_pkg::mode_t next_state;

   logic [1:0]  power_mode_control;
   logic [31:0] peripheral_clock_enable;
   logic [7:0]  wake_count;
   logic [1:0]  tick_count;
   logic [WAKE_COUNT-1:0] wake_level;
   logic        ext_event;
   logic        idle_wake;
   logic        aw_held;
   logic        w_held;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        write_go;
   logic        wr_mode;
   logic        wr_enable;
   logic        clocks_on;

   // external wake pins arrive with no clock relation
   pin_sync3 #(
      .WIDTH (WAKE_COUNT)
   ) u_wake_sync (
      .clock (clock),
      .rst_n (rst_n),
      .pin   (ext_wake),
      .level (wake_level)
   );

   assign ext_event = |wake_level;
   assign idle_wake = ext_event | (|periph_irq);

   // ---------------- register bus, write side ----------------

   // address and data are taken in either order, then applied together
   assign awready  = !aw_held && !bvalid;
   assign wready   = !w_held && !bvalid;
   assign write_go = aw_held && w_held && !bvalid;
   assign wr_mode  = write_go &&
      aw_addr_q == power_mode_pkg::POWER_MODE_CONTROL_ADDR;
   assign wr_enable = write_go &&
      aw_addr_q == power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_ADDR;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_held   <= 1'b0;
         aw_addr_q <= 32'h00000000;
      end else if (awvalid && awready) begin
         aw_held   <= 1'b1;
         aw_addr_q <= awaddr;
      end else if (write_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         w_held   <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (wvalid && wready) begin
         w_held   <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end else if (write_go) begin
         w_held <= 1'b0;
      end
   end

   // response one cycle after both halves are held; unmapped is an error
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= power_mode_pkg::RESP_OKAY;
      end else if (write_go) begin
         bvalid <= 1'b1;
         bresp  <= (wr_mode || wr_enable) ? power_mode_pkg::RESP_OKAY
                                          : power_mode_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ---------------- register bus, read side ----------------

   assign arready = !rvalid;

   // reserved bits read as zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= power_mode_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp  <= power_mode_pkg::RESP_OKAY;
         if (araddr == power_mode_pkg::POWER_MODE_CONTROL_ADDR) begin
            rdata <= {30'h00000000, power_mode_control};
         end else if (araddr ==
                      power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_ADDR) begin
            rdata <= peripheral_clock_enable;
         end else begin
            rdata <= 32'h00000000;
            rresp <= power_mode_pkg::RESP_SLVERR;
         end
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ---------------- power mode register ----------------

   // hardware clears both mode bits on a power-down wake and the sleep bit on an idle wake; a write in the same cycle wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_mode_control <= power_mode_pkg::POWER_MODE_CONTROL_RESET;
      end else if (wr_mode && w_strb_q[0]) begin
         power_mode_control <= w_data_q[1:0];
      end else if (state == power_mode_pkg::MODE_DOWN && ext_event) begin
         power_mode_control <= 2'h0;
      end else if (state == power_mode_pkg::MODE_IDLE && idle_wake) begin
         power_mode_control[power_mode_pkg::PROCESSOR_SLEEP_BIT] <= 1'b0;
      end
   end

   // ---------------- peripheral enable register ----------------

   // byte lanes honoured; unused bits never store a one
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         peripheral_clock_enable <=
            power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_RESET;
      end else if (wr_enable) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
               peripheral_clock_enable[b*8 +: 8] <= w_data_q[b*8 +: 8] &
                  power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_USED[b*8 +: 8];
            end
         end
      end
   end

   // ---------------- mode sequencer ----------------

   // deep sleep is checked first so both bits together mean power-down
   always_comb begin
      next_state = state;
      unique case (state)
         power_mode_pkg::MODE_RUN: begin
            if (power_mode_control[power_mode_pkg::DEEP_SLEEP_BIT]) begin
               next_state = power_mode_pkg::MODE_DOWN;
            end else if (
               power_mode_control[power_mode_pkg::PROCESSOR_SLEEP_BIT]) begin
               next_state = power_mode_pkg::MODE_IDLE;
            end
         end
         power_mode_pkg::MODE_IDLE: begin
            if (idle_wake) next_state = power_mode_pkg::MODE_RUN;
         end
         power_mode_pkg::MODE_DOWN: begin
            // only the clockless wake pins can end power-down
            if (ext_event) next_state = power_mode_pkg::MODE_WAKE;
         end
         power_mode_pkg::MODE_WAKE: begin
            if (wake_count == 8'h01) next_state = power_mode_pkg::MODE_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= power_mode_pkg::MODE_RUN;
      end else begin
         state <= next_state;
      end
   end

   // oscillator settle time before clocks are released again
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_count <= 8'h00;
      end else if (next_state == power_mode_pkg::MODE_WAKE &&
                   state == power_mode_pkg::MODE_DOWN) begin
         wake_count <= START_CYCLES;
      end else if (state == power_mode_pkg::MODE_WAKE) begin
         wake_count <= wake_count - 8'h01;
      end
   end

   // clock outputs follow the next mode so they change with the state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clock_en <= 1'b1;
         osc_enable   <= 1'b1;
         pin_hold     <= 1'b0;
         cpu_resume   <= 1'b0;
      end else begin
         cpu_clock_en <= next_state == power_mode_pkg::MODE_RUN;
         osc_enable   <= next_state != power_mode_pkg::MODE_DOWN;
         pin_hold     <= next_state == power_mode_pkg::MODE_DOWN ||
                         next_state == power_mode_pkg::MODE_WAKE;
         // one pulse: the processor restarts at the instruction it stopped
         cpu_resume   <= next_state == power_mode_pkg::MODE_RUN &&
                         state != power_mode_pkg::MODE_RUN;
      end
   end

   // peripherals keep running in idle but not while the oscillator is off
   assign clocks_on = state == power_mode_pkg::MODE_RUN ||
                      state == power_mode_pkg::MODE_IDLE;

   // peripheral clock enable pulse; held high outside run and idle so the gates clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tick_count <= 2'h0;
         pclk_tick  <= 1'b0;
      end else if (!clocks_on) begin
         tick_count <= 2'h0;
         pclk_tick  <= 1'b1;
      end else begin
         tick_count <= (tick_count == TICK_LAST) ? 2'h0 : tick_count + 2'h1;
         pclk_tick  <= tick_count == TICK_LAST;
      end
   end

   // ungated units stop in power-down and during the oscillator settle time
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         always_on_en <= 1'b1;
      end else begin
         always_on_en <= clocks_on;
      end
   end

   // second serial port turns into the synchronous serial port
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ssp_select <= 1'b0;
      end else begin
         ssp_select <=
            peripheral_clock_enable[power_mode_pkg::SYNC_SERIAL_GATE] &&
            !peripheral_clock_enable[power_mode_pkg::SERIAL_PORT1_GATE];
      end
   end

   // one enable per register bit: timers, serial, two-wire, calendar,
   // memory controller, converter and field buses at their positions
   clock_gate_bank #(
      .WIDTH (32)
   ) u_gates (
      .clock       (clock),
      .rst_n       (rst_n),
      .pclk_tick   (pclk_tick),
      .run         (clocks_on),
      .request     (peripheral_clock_enable),
      .reset_value (power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_RESET),
      .enable      (periph_clock_en)
   );

   // ---------------- checks ----------------

   a_down_priority: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_RUN && power_mode_control == 2'h3
      |=> state == power_mode_pkg::MODE_DOWN)
      else $error("both mode bits did not give power-down");

   a_idle_entry: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_RUN && power_mode_control == 2'h1
      |=> state == power_mode_pkg::MODE_IDLE && !cpu_clock_en
          && osc_enable)
      else $error("idle entry did not stop only the processor");

   a_idle_exit: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_IDLE && |periph_irq
      |=> state == power_mode_pkg::MODE_RUN && cpu_clock_en
          && cpu_resume)
      else $error("interrupt did not end idle");

   a_down_clocks: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_RUN &&
      power_mode_control[power_mode_pkg::DEEP_SLEEP_BIT]
      |=> !osc_enable && !cpu_clock_en && pin_hold ##1 !always_on_en)
      else $error("power-down left a clock running");

   a_down_hold: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_DOWN && !ext_event && !wr_mode
      |=> state == power_mode_pkg::MODE_DOWN && pin_hold)
      else $error("power-down ended without a wake pin");

   a_wake_clear: assert property (@(posedge clock) disable iff (!rst_n)
      state == power_mode_pkg::MODE_DOWN && ext_event && !wr_mode
      |=> osc_enable && !power_mode_control[1])
      else $error("wake did not restart oscillator or clear the bit");

   a_wake_time: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(state == power_mode_pkg::MODE_WAKE)
      |-> ##199 state == power_mode_pkg::MODE_WAKE
          ##1 state == power_mode_pkg::MODE_RUN)
      else $error("oscillator settle time wrong");

   a_resume_once: assert property (@(posedge clock) disable iff (!rst_n)
      cpu_resume |-> cpu_clock_en ##1 !cpu_resume)
      else $error("resume pulse repeated");

   a_ssp_route: assert property (@(posedge clock) disable iff (!rst_n)
      peripheral_clock_enable[23] && !peripheral_clock_enable[10]
      |=> ssp_select)
      else $error("synchronous serial not selected");

endmodule

// >>> verification/power_mode_clock_gating_tb_top.sv
// self-checking bench for the power mode and clock gating block
// assumes power_mode_pkg is compiled first; bench is the only bus master
`timescale 1ns/1ps
module power_mode_clock_gating_tb_top;
   localparam logic [31:0] MA   = power_mode_pkg::POWER_MODE_CONTROL_ADDR;
   localparam logic [31:0] EA   = power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_ADDR;
   localparam logic [31:0] USED = power_mode_pkg::PERIPHERAL_CLOCK_ENABLE_USED;
   localparam logic [1:0]  OK   = power_mode_pkg::RESP_OKAY;
   localparam logic [1:0]  ERR  = power_mode_pkg::RESP_SLVERR;
   localparam int          OSC  = power_mode_pkg::OSC_START_CYCLES;
   logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, cpu_clock_en;
   logic        cpu_resume, osc_enable, pin_hold, always_on_en, pclk_tick;
   logic        ssp_select;
   logic [31:0] awaddr, wdata, araddr, rdata, periph_clock_en;
   logic [1:0]  bresp, rresp;
   logic [3:0]  wstrb, ext_wake;
   logic [15:0] periph_irq;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          fails, check_count;
   integer      seed = 32'hDB60B2A2;

   power_mode_clock_gating dut (
      .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .periph_irq(periph_irq), .ext_wake(ext_wake),
      .cpu_clock_en(cpu_clock_en), .cpu_resume(cpu_resume),
      .osc_enable(osc_enable), .pin_hold(pin_hold),
      .always_on_en(always_on_en), .periph_clock_en(periph_clock_en),
      .pclk_tick(pclk_tick), .ssp_select(ssp_select));

   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task results;
      if (fails == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watcher: each answer taken is matched with the oldest note
   always @(posedge clock) begin
      if (rvalid && rready)
         chk("read", rq.pop_front(), {rresp, rdata});
      if (bvalid && bready)
         chk("bresp", bq.pop_front(), bresp);
   end

   // one write or read; ready is looked at mid-cycle, where it is settled
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
             input logic [1:0] e);
      logic at, wt, bt, art, rt;
      if (w)
         bq.push_back(e);
      else
         rq.push_back({e, d});
      @(posedge clock);
      if (w) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      for (int i = 0; i < 50; i++) begin
         @(negedge clock);
         at = awvalid && awready;
         wt = wvalid && wready;
         bt = bvalid && bready;
         art = arvalid && arready;
         rt = rvalid && rready;
         @(posedge clock);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         if (art) arvalid <= 1'b0;
         if (bt) bready <= 1'b0;
         if (rt) rready <= 1'b0;
         if (bt || rt) return;
      end
      chk("bus", 0, 1);
      results();
   endtask

   // bounded wait for an output to reach a value; a hang ends the run
   task wait_sig(input int s, input logic [31:0] v, input int lim,
                 output int n);
      logic [31:0] x;
      for (n = 0; n < lim; n++) begin
         @(negedge clock);
         case (s)
            0: x = {31'h0, cpu_clock_en};
            1: x = {31'h0, osc_enable};
            2: x = {31'h0, cpu_resume};
            default: x = periph_clock_en;
         endcase
         if (x === v) break;
      end
      chk("wait", v, x);
      if (x !== v) results();
   endtask

   // main sequence: reset, registers, gates, idle, power-down, reset
   initial begin
      int          n;
      logic [31:0] d;
      int          gl[15] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13, 14, 16,
                              23};
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr} = '0;
      {periph_irq, ext_wake} = '0;
      wstrb = 4'hF;
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      wait_sig(3, 32'h1FBE, 4, n);
      chk("ssp", 0, ssp_select);
      xfer(0, EA, 32'h1FBE, OK);
      xfer(0, MA, 0, OK);
      xfer(1, 32'hE01FC0C8, 32'hFFFFFFFF, ERR);
      xfer(0, 32'hE01FC0C8, 0, ERR);
      xfer(0, EA, 32'h1FBE, OK);
      foreach (gl[i]) begin
         xfer(1, EA, 32'h1 << gl[i], OK);
         wait_sig(3, 32'h1 << gl[i], 20, n);
         chk("ssp", gl[i] == 23, ssp_select);
         chk("on", 1, always_on_en);
      end
      repeat (4) begin
         d = $random(seed);
         xfer(1, EA, d, OK);
         xfer(0, EA, d & USED, OK);
         wait_sig(3, d & USED, 20, n);
         chk("ssp", d[23] & ~d[10], ssp_select);
      end
      // partial lanes: only byte one of the enable register is cleared
      wstrb <= 4'h2;
      xfer(1, EA, 32'h0, OK);
      xfer(0, EA, d & USED & 32'hFFFF00FF, OK);
      // mode register listens to lane zero only
      wstrb <= 4'hE;
      xfer(1, MA, 3, OK);
      xfer(0, MA, 0, OK);
      wstrb <= 4'hF;
      xfer(1, EA, USED, OK);
      xfer(1, MA, 1, OK);
      wait_sig(0, 0, 5, n);
      n = 0;
      repeat (16) begin
         @(negedge clock);
         n += pclk_tick;
      end
      chk("tick", 4, n);
      chk("osc", 1, osc_enable);
      chk("gates", USED, periph_clock_en);
      @(posedge clock);
      periph_irq <= 16'h1 << ($random(seed) & 15);
      wait_sig(2, 1, 6, n);
      chk("cpu", 1, cpu_clock_en);
      @(posedge clock);
      periph_irq <= '0;
      xfer(0, MA, 0, OK);
      xfer(1, MA, 3, OK);
      wait_sig(1, 0, 5, n);
      chk("cpu", 0, cpu_clock_en);
      chk("hold", 1, pin_hold);
      wait_sig(3, 0, 20, n);
      chk("on", 0, always_on_en);
      @(posedge clock);
      periph_irq <= '1;
      repeat (10) @(negedge clock);
      chk("osc", 0, osc_enable);
      @(posedge clock);
      periph_irq <= '0;
      ext_wake <= 4'h1 << ($random(seed) & 3);
      wait_sig(1, 1, 12, n);
      @(posedge clock);
      ext_wake <= '0;
      wait_sig(2, 1, 300, n);
      chk("settle", 1, (n + 12 > OSC) && (n < OSC + 4));
      chk("hold", 0, pin_hold);
      wait_sig(3, USED, 20, n);
      xfer(0, MA, 0, OK);
      xfer(0, EA, USED, OK);
      xfer(1, MA, 1, OK);
      wait_sig(0, 0, 5, n);
      @(posedge clock);
      rst_n <= 1'b0;
      @(negedge clock);
      chk("cpu", 1, cpu_clock_en);
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      xfer(0, EA, 32'h1FBE, OK);
      xfer(0, MA, 0, OK);
      results();
   end
endmodule
